// ==== core/i2c_ctrl_consts.svh ====
/*
 * Register indices, field positions and reset values of the I2C control block.
 * Assumes a byte address on the register bus equal to four times the index.
 */
`ifndef I2C_CTRL_CONSTS_SVH
`define I2C_CTRL_CONSTS_SVH

`define IDX_CLOCK_SELECT 10'h3c0
`define IDX_ADDRESS_MODE 10'h3c2
`define IDX_BIT_RATE 10'h3c4
`define IDX_SLAVE_ADDRESS 10'h3c8
`define IDX_COMMAND_CONTROL 10'h3ca
`define IDX_TRANSMIT_BUFFER 10'h3cc
`define IDX_RECEIVE_BUFFER 10'h3ce
`define IDX_STATUS_FLAGS 10'h3d0
`define IDX_INTERRUPT_MASK 10'h3d2

`define CLK_SRC_BIT 0
`define CLK_DIV_HI 5
`define CLK_DIV_LO 4
`define MODE_TEN_BIT 2
`define MODE_GC_BIT 1
`define RATE_RESET 7'h7f
`define CTL_ENABLE 0
`define CTL_SOFT_RESET 1
`define CTL_START 2
`define CTL_STOP 3
`define CTL_NACK 4
`define CTL_MASTER 5
`define ST_SDA_LOW 12
`define ST_SCL_LOW 11
`define ST_BUSY 10
`define ST_TR 9

`define F_TBE 0
`define F_RBF 1
`define F_ERR 2
`define F_START 3
`define F_STOP 4
`define F_NACK 5
`define F_GC 6
`define F_BYTEEND 7

`define GC_ADDR 8'h00
`define TEN_BIT_HDR 5'h1e
`define LAST_BIT 4'h8
`define ACK_BIT 4'h9

`endif

// ==== core/i2c_ctrl_pkg.sv ====
/*
 * Types shared by the I2C control block files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_ctrl_pkg;
	typedef enum logic [5:0] {
		st_idle = 6'b000001,
		st_start = 6'b000010,
		st_hold = 6'b000100,
		st_byte = 6'b001000,
		st_stop = 6'b010000,
		st_slave = 6'b100000
	} eng_state_e;
endpackage

// ==== core/i2c_master_slave_control.sv ====
/*
 * I2C master/slave controller with its register file on an Avalon-MM slave.
 * Assumes bus pins are open drain, resolved outside, and sampled synchronously.
 */
`timescale 1ns/1ps
`include "i2c_ctrl_consts.svh"
// Summary of operation
// - Source bit picks fast or low-speed oscillator
// - Divider 1,2,4,8 on fast; low-speed undivided
// - Address-width bit picks ten or seven bits
// - General-call enable bit answers address zero
// - Seven-bit rate field, resets to all ones
// - Control bit positions enable through master
// - Receive byte read-only, upper bits zero
// - Transmit-empty flag bit zero, write-one clears
module i2c_master_slave_control import i2c_ctrl_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Oscillator ticks
	input wire logic fast_osc_tick,
	input wire logic low_osc_tick,
	// Bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Interrupt
	output logic irq
);
	generate
		if (ADDR_W < 12) begin : bad_addr
			$error("i2c_master_slave_control: address too narrow");
		end
	endgenerate

	logic clock_source_select;
	logic [1:0] clock_divider;
	logic own_addr_ten_bit;
	logic general_call_respond;
	logic [6:0] bit_rate_setting;
	logic [9:0] own_slave_address;
	logic unit_enable;
	logic soft_reset_request;
	logic send_start_request;
	logic send_stop_request;
	logic send_nack_request;
	logic master_select;
	logic [7:0] tx_data;
	logic tx_full;
	logic [7:0] rx_data;
	logic [7:0] i2c_status_flags;
	logic [7:0] interrupt_mask;
	logic en_q;
	logic bus_ack;
	logic [15:0] rd_mux;
	logic [7:0] flag_clr;
	logic wr_acc;
	logic rd_acc;
	logic phase_tick;
	eng_state_e state;
	logic [1:0] phase;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic transmitting;
	logic scl_low;
	logic sda_low;
	logic [1:0] slave_phase;
	logic got_nack;
	logic dir_read;
	logic first_byte;
	logic [7:0] ev;
	logic tx_load;
	logic start_done;
	logic stop_done;
	logic nack_done;
	logic scl_q;
	logic sda_q;
	logic bus_busy;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic eng_clr;
	logic gc_hit;
	logic own7_hit;
	logic hdr_hit;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		hit = (a == ADDR_W'({idx, 2'b00}));
	endfunction

	// Request is held one cycle under waitrequest so read data come from a flop
	assign waitrequest = (read || write) && !bus_ack;
	assign wr_acc = write && bus_ack;
	assign rd_acc = read && bus_ack;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_ack <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			bus_ack <= (read || write) && !bus_ack;
			if (read && !bus_ack) begin
				readdata <= {16'h0000, rd_mux};
			end
		end
	end

	// Unmapped addresses read as zero and ignore writes
	always_comb begin
		rd_mux = 16'h0000;
		if (hit(address, `IDX_CLOCK_SELECT)) begin
			rd_mux[`CLK_SRC_BIT] = clock_source_select;
			rd_mux[`CLK_DIV_HI:`CLK_DIV_LO] = clock_divider;
		end else if (hit(address, `IDX_ADDRESS_MODE)) begin
			rd_mux[`MODE_TEN_BIT] = own_addr_ten_bit;
			rd_mux[`MODE_GC_BIT] = general_call_respond;
		end else if (hit(address, `IDX_BIT_RATE)) begin
			rd_mux[6:0] = bit_rate_setting;
		end else if (hit(address, `IDX_SLAVE_ADDRESS)) begin
			rd_mux[9:0] = own_slave_address;
		end else if (hit(address, `IDX_COMMAND_CONTROL)) begin
			rd_mux[`CTL_ENABLE] = unit_enable;
			rd_mux[`CTL_SOFT_RESET] = soft_reset_request;
			rd_mux[`CTL_START] = send_start_request;
			rd_mux[`CTL_STOP] = send_stop_request;
			rd_mux[`CTL_NACK] = send_nack_request;
			rd_mux[`CTL_MASTER] = master_select;
		end else if (hit(address, `IDX_TRANSMIT_BUFFER)) begin
			rd_mux[7:0] = tx_data;
		end else if (hit(address, `IDX_RECEIVE_BUFFER)) begin
			rd_mux[7:0] = rx_data;
		end else if (hit(address, `IDX_STATUS_FLAGS)) begin
			rd_mux[7:0] = i2c_status_flags;
			rd_mux[`ST_SDA_LOW] = !sda_in;
			rd_mux[`ST_SCL_LOW] = !scl_in;
			rd_mux[`ST_BUSY] = bus_busy;
			rd_mux[`ST_TR] = transmitting;
		end else if (hit(address, `IDX_INTERRUPT_MASK)) begin
			rd_mux[7:0] = interrupt_mask;
		end
	end

	// Address mode and bit rate are locked while enabled; clock select, slave address and mask are not
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clock_source_select <= 1'b0;
			clock_divider <= 2'h0;
			own_addr_ten_bit <= 1'b0;
			general_call_respond <= 1'b0;
			bit_rate_setting <= `RATE_RESET;
			own_slave_address <= 10'h000;
			interrupt_mask <= 8'h00;
		end else if (wr_acc && byteenable[0]) begin
			if (hit(address, `IDX_CLOCK_SELECT)) begin
				clock_source_select <= writedata[`CLK_SRC_BIT];
				clock_divider <= writedata[`CLK_DIV_HI:`CLK_DIV_LO];
			end
			if (hit(address, `IDX_ADDRESS_MODE) && !unit_enable) begin
				own_addr_ten_bit <= writedata[`MODE_TEN_BIT];
				general_call_respond <= writedata[`MODE_GC_BIT];
			end
			if (hit(address, `IDX_BIT_RATE) && !unit_enable) begin
				bit_rate_setting <= writedata[6:0];
			end
			if (hit(address, `IDX_SLAVE_ADDRESS)) begin
				own_slave_address[7:0] <= writedata[7:0];
				if (byteenable[1]) own_slave_address[9:8] <= writedata[9:8];
			end
			if (hit(address, `IDX_INTERRUPT_MASK)) begin
				interrupt_mask <= writedata[7:0];
			end
		end else if (wr_acc && byteenable[1] && hit(address, `IDX_SLAVE_ADDRESS)) begin
			own_slave_address[9:8] <= writedata[9:8];
		end
	end

	// Control bits; start and stop are only accepted together with master
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit_enable <= 1'b0;
			soft_reset_request <= 1'b0;
			send_start_request <= 1'b0;
			send_stop_request <= 1'b0;
			send_nack_request <= 1'b0;
			master_select <= 1'b0;
		end else if (wr_acc && byteenable[0] && hit(address, `IDX_COMMAND_CONTROL)) begin
			unit_enable <= writedata[`CTL_ENABLE];
			master_select <= writedata[`CTL_MASTER];
			soft_reset_request <= writedata[`CTL_SOFT_RESET];
			send_start_request <= (send_start_request && !start_done)
				|| (writedata[`CTL_START] && writedata[`CTL_MASTER]);
			send_stop_request <= (send_stop_request && !stop_done)
				|| (writedata[`CTL_STOP] && writedata[`CTL_MASTER]);
			send_nack_request <= (send_nack_request && !nack_done) || writedata[`CTL_NACK];
		end else if (soft_reset_request) begin
			soft_reset_request <= 1'b0;
			send_start_request <= 1'b0;
			send_stop_request <= 1'b0;
			send_nack_request <= 1'b0;
		end else begin
			if (start_done) send_start_request <= 1'b0;
			if (stop_done) send_stop_request <= 1'b0;
			if (nack_done) send_nack_request <= 1'b0;
		end
	end

	// A write in the cycle of the engine's tx_load pulse wins, keeping the new byte
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_data <= 8'h00;
			tx_full <= 1'b0;
		end else if (wr_acc && byteenable[0] && hit(address, `IDX_TRANSMIT_BUFFER)) begin
			tx_data <= writedata[7:0];
			tx_full <= 1'b1;
		end else if (tx_load || soft_reset_request) begin
			tx_full <= 1'b0;
		end
	end

	// Read clears all, write-one clears chosen bits; a new event wins over both, but a soft reset drops it
	always_comb begin
		flag_clr = 8'h00;
		if (rd_acc && hit(address, `IDX_STATUS_FLAGS)) begin
			flag_clr = 8'hff;
		end else if (wr_acc && byteenable[0] && hit(address, `IDX_STATUS_FLAGS)) begin
			flag_clr = writedata[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			i2c_status_flags <= 8'h00;
			en_q <= 1'b0;
		end else begin
			en_q <= unit_enable;
			if (soft_reset_request) begin
				i2c_status_flags <= 8'h00;
				// The reset empties the transmit buffer, so it is ready for a byte
				i2c_status_flags[`F_TBE] <= unit_enable;
			end else begin
				i2c_status_flags <= (i2c_status_flags & ~flag_clr) | ev;
				if (unit_enable && !en_q && !tx_full) begin
					i2c_status_flags[`F_TBE] <= 1'b1;
				end
			end
		end
	end

	assign irq = |(i2c_status_flags & interrupt_mask);

	// Open drain: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_low;
	assign sda_oe = sda_low;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bus_busy <= 1'b0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (start_seen) bus_busy <= 1'b1;
			else if (stop_seen) bus_busy <= 1'b0;
		end
	end

	assign start_seen = scl_in && scl_q && sda_q && !sda_in;
	assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
	assign scl_rise = scl_in && !scl_q;
	assign scl_fall = !scl_in && scl_q;
	assign eng_clr = soft_reset_request || !unit_enable;
	assign gc_hit = (shift == `GC_ADDR) && general_call_respond;
	assign own7_hit = !own_addr_ten_bit && (shift[7:1] == own_slave_address[6:0]);
	assign hdr_hit = own_addr_ten_bit && (shift[7:3] == `TEN_BIT_HDR)
		&& (shift[2:1] == own_slave_address[9:8]);

	i2c_rate_ticker #(
		.RATE_W(7),
		.DIV_W(2)
	) u_ticker (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.enable(unit_enable),
		.fast_osc_tick(fast_osc_tick),
		.low_osc_tick(low_osc_tick),
		.clock_source_select(clock_source_select),
		.clock_divider(clock_divider),
		.bit_rate_setting(bit_rate_setting),
		.phase_tick(phase_tick)
	);

	// Master bits run on four quarter-bit phases; slave bits follow the clock edges
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= st_idle;
			phase <= 2'h0;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			transmitting <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			slave_phase <= 2'h0;
			got_nack <= 1'b0;
			dir_read <= 1'b0;
			first_byte <= 1'b0;
			ev <= 8'h00;
			tx_load <= 1'b0;
			start_done <= 1'b0;
			stop_done <= 1'b0;
			nack_done <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			ev <= 8'h00;
			tx_load <= 1'b0;
			start_done <= 1'b0;
			stop_done <= 1'b0;
			nack_done <= 1'b0;
			if (eng_clr) begin
				state <= st_idle;
				scl_low <= 1'b0;
				sda_low <= 1'b0;
				bit_cnt <= 4'h0;
				transmitting <= 1'b0;
			end else begin
				unique case (state)
					st_idle: begin
						scl_low <= 1'b0;
						sda_low <= 1'b0;
						if (master_select && send_start_request && !bus_busy) begin
							state <= st_start;
							phase <= 2'h0;
						end else if (!master_select && start_seen) begin
							state <= st_slave;
							bit_cnt <= 4'h0;
							slave_phase <= 2'h0;
							transmitting <= 1'b0;
							ev[`F_START] <= 1'b1;
						end
					end
					// A stretched clock delays the data-line edge of start and stop
					st_start: if (phase_tick && !(phase == 2'h2 && !scl_in)) begin
						phase <= phase + 2'h1;
						case (phase)
							2'h0: sda_low <= 1'b0;
							2'h1: scl_low <= 1'b0;
							2'h2: sda_low <= 1'b1;
							default: begin
								scl_low <= 1'b1;
								start_done <= 1'b1;
								ev[`F_START] <= 1'b1;
								state <= st_hold;
								transmitting <= 1'b1;
								first_byte <= 1'b1;
							end
						endcase
					end
					st_hold: begin
						sda_low <= 1'b0;
						phase <= 2'h0;
						bit_cnt <= 4'h0;
						if (send_stop_request) begin
							state <= st_stop;
						end else if (send_start_request && !start_done) begin
						// The request bit drops only one cycle after its done pulse
							state <= st_start;
						end else if (transmitting && tx_full) begin
							shift <= tx_data;
							tx_load <= 1'b1;
							ev[`F_TBE] <= 1'b1;
							if (first_byte) dir_read <= tx_data[0];
							state <= st_byte;
						end else if (!transmitting && !i2c_status_flags[`F_RBF]) begin
							state <= st_byte;
						end
					end
					st_byte: if (phase_tick && !(phase == 2'h2 && !scl_in)) begin
						// A slave stretching the clock holds the sampling phase
						phase <= phase + 2'h1;
						case (phase)
							2'h0: begin
								if (bit_cnt < `LAST_BIT) sda_low <= transmitting && !shift[7];
								else sda_low <= !transmitting && !send_nack_request;
							end
							2'h1: scl_low <= 1'b0;
							2'h2: begin
								if (bit_cnt < `LAST_BIT) begin
									shift <= {shift[6:0], sda_in};
									if (transmitting && !sda_low && !sda_in) begin
										ev[`F_ERR] <= 1'b1;
										state <= st_idle;
									end
								end else begin
									got_nack <= sda_in;
								end
							end
							default: begin
								scl_low <= 1'b1;
								if (bit_cnt < `LAST_BIT) begin
									bit_cnt <= bit_cnt + 4'h1;
								end else begin
									state <= st_hold;
									first_byte <= 1'b0;
									ev[`F_BYTEEND] <= 1'b1;
									if (transmitting) begin
										if (got_nack) ev[`F_NACK] <= 1'b1;
										else if (first_byte && dir_read) transmitting <= 1'b0;
									end else begin
										rx_data <= shift;
										ev[`F_RBF] <= 1'b1;
										if (send_nack_request) nack_done <= 1'b1;
									end
								end
							end
						endcase
					end
					st_stop: if (phase_tick && !(phase == 2'h2 && !scl_in)) begin
						phase <= phase + 2'h1;
						case (phase)
							2'h0: sda_low <= 1'b1;
							2'h1: scl_low <= 1'b0;
							2'h2: sda_low <= 1'b0;
							default: begin
								stop_done <= 1'b1;
								ev[`F_STOP] <= 1'b1;
								state <= st_idle;
							end
						endcase
					end
					st_slave: begin
						if (stop_seen) begin
							state <= st_idle;
							sda_low <= 1'b0;
							ev[`F_STOP] <= 1'b1;
						end else if (start_seen) begin
							bit_cnt <= 4'h0;
							slave_phase <= 2'h0;
							transmitting <= 1'b0;
							sda_low <= 1'b0;
							ev[`F_START] <= 1'b1;
						end else if (scl_rise) begin
							if (bit_cnt < `LAST_BIT) begin
								shift <= {shift[6:0], sda_in};
								bit_cnt <= bit_cnt + 4'h1;
							end else if (bit_cnt == `LAST_BIT) begin
								got_nack <= sda_in;
								bit_cnt <= `ACK_BIT;
							end
						end else if (scl_fall) begin
							if (bit_cnt == `LAST_BIT) begin
								sda_low <= 1'b0;
								if (slave_phase == 2'h0) begin
									if (gc_hit) begin
										sda_low <= 1'b1;
										ev[`F_GC] <= 1'b1;
										slave_phase <= 2'h2;
										transmitting <= 1'b0;
									end else if (own7_hit) begin
										sda_low <= 1'b1;
										slave_phase <= 2'h2;
										transmitting <= shift[0];
									end else if (hdr_hit) begin
										sda_low <= 1'b1;
										slave_phase <= shift[0] ? 2'h2 : 2'h1;
										transmitting <= shift[0];
									end else begin
										state <= st_idle;
									end
								end else if (slave_phase == 2'h1) begin
									if (shift == own_slave_address[7:0]) begin
										sda_low <= 1'b1;
										slave_phase <= 2'h2;
									end else begin
										state <= st_idle;
									end
								end else if (!transmitting) begin
									sda_low <= !send_nack_request;
									if (send_nack_request) nack_done <= 1'b1;
									rx_data <= shift;
									ev[`F_RBF] <= 1'b1;
								end
							end else if (bit_cnt == `ACK_BIT) begin
								bit_cnt <= 4'h0;
								sda_low <= 1'b0;
								ev[`F_BYTEEND] <= 1'b1;
								if (transmitting) begin
									if (got_nack) begin
										ev[`F_NACK] <= 1'b1;
										state <= st_idle;
									end else begin
										// An empty buffer still shifts its old byte, flagged
										shift <= tx_data;
										tx_load <= 1'b1;
										ev[`F_TBE] <= 1'b1;
										ev[`F_ERR] <= !tx_full;
										sda_low <= !tx_data[7];
									end
								end
							end else if (transmitting && bit_cnt != 4'h0) begin
								sda_low <= !shift[7];
							end
						end
					end
					default: state <= st_idle;
				endcase
			end
		end
	end
endmodule

// ==== core/i2c_rate_ticker.sv ====
/*
 * Source select, divider and rate counter giving one quarter-bit enable pulse.
 * Assumes both oscillator ticks are one-cycle pulses synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "i2c_ctrl_consts.svh"
module i2c_rate_ticker #(
	parameter int RATE_W = 7,
	parameter int DIV_W = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Sources and settings
	input wire logic enable,
	input wire logic fast_osc_tick,
	input wire logic low_osc_tick,
	input wire logic clock_source_select,
	input wire logic [DIV_W-1:0] clock_divider,
	input wire logic [RATE_W-1:0] bit_rate_setting,
	// Quarter-bit enable
	output logic phase_tick
);
	generate
		if (RATE_W < 1 || DIV_W != 2) begin : bad_width
			$error("i2c_rate_ticker: unsupported width");
		end
	endgenerate

	logic src_tick;
	logic clk_tick;
	logic [2:0] div_cnt;
	logic [2:0] div_last;
	logic [RATE_W-1:0] rate_cnt;

	assign src_tick = clock_source_select ? low_osc_tick : fast_osc_tick;
	// Low-speed source ignores the divider code
	assign div_last = clock_source_select ? 3'h0 : 3'((4'h1 << clock_divider) - 4'h1);
	assign clk_tick = src_tick && (div_cnt >= div_last);

	// Disable stops every count, which is the gated operating clock
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= 3'h0;
		end else if (!enable || clk_tick) begin
			div_cnt <= 3'h0;
		end else if (src_tick) begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// A zero rate ticks on every divided clock, the same as a rate of one, rather than stalling
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rate_cnt <= '0;
			phase_tick <= 1'b0;
		end else begin
			phase_tick <= 1'b0;
			if (!enable) begin
				rate_cnt <= '0;
			end else if (clk_tick) begin
				if (rate_cnt + 1'b1 >= bit_rate_setting) begin
					rate_cnt <= '0;
					phase_tick <= 1'b1;
				end else begin
					rate_cnt <= rate_cnt + 1'b1;
				end
			end
		end
	end
endmodule

// ==== dv/i2c_bus_partner.sv ====
/*
 * Far side of the bus: pull-ups and a target acknowledging every byte.
 * Assumes open-drain enables from the block; slow stretches each low phase.
 */
`timescale 1ns/1ps
module i2c_bus_partner (
	// Clock
	input wire logic ref_clk,
	// Block side
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic slow,
	// Resolved lines
	output logic scl,
	output logic sda
);
	logic ps = 1'b1, pd = 1'b1, hold_sda = 1'b0;
	logic [3:0] bits = 4'h0;
	logic [4:0] hold = 5'h0;
	// Pull-ups: a released line reads high, never the last driven value
	assign scl = !(scl_oe || hold != 5'h0);
	assign sda = !(sda_oe || hold_sda);
	always @(posedge ref_clk) begin
		ps <= scl;
		pd <= sda;
		if (scl && pd && !sda) begin
			bits <= 4'h0;
		end else if (!ps && scl) begin
			bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
		end
		// Ack only while the clock is low, so it never looks like a stop
		if (ps && !scl) begin
			hold_sda <= (bits == 4'h8);
			hold <= slow ? 5'h10 : 5'h0;
		end else if (hold != 5'h0) begin
			hold <= hold - 5'h1;
		end
	end
endmodule

// ==== dv/i2c_ctrl_asserts.sv ====
/*
 * Port checker for the I2C control block.
 * Assumes one clock domain and the async active-low reset.
 */
`timescale 1ns/1ps
`include "i2c_ctrl_consts.svh"
module i2c_ctrl_asserts #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register bus
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Bus pins and interrupt
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic [9:0] idx = address[11:2];
	wire logic rd = read && !waitrequest;
	wire logic ctl = write && !waitrequest && idx == `IDX_COMMAND_CONTROL && byteenable[0];
	wire logic idle = !scl_oe && !sda_oe && scl_in && sda_in;
	AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request held more than one wait state");
	AST_UPPER_ZERO: assert property (rd |-> readdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	AST_RX_BYTE: assert property (rd && idx == `IDX_RECEIVE_BUFFER
		|-> readdata[15:8] == 8'h0)
		else $error("receive buffer upper byte not zero");
	AST_CTL_LAYOUT: assert property (rd && idx == `IDX_COMMAND_CONTROL
		|-> readdata[15:6] == 10'h0 && !readdata[1])
		else $error("control readback has stray bits");
	AST_RATE_NONZERO: assert property (rd && idx == `IDX_BIT_RATE
		|-> readdata[6:0] != 7'h0 && readdata[15:7] == 9'h0)
		else $error("rate field read zero or wide");
	AST_READ_HOLDS: assert property ($changed(readdata) |-> $past(read))
		else $error("read data moved without a read");
	AST_DISABLE_RELEASE: assert property (ctl && !writedata[0]
		|-> ##2 (!scl_oe && !sda_oe) [*4])
		else $error("lines driven after disable");
	AST_START_SEQ: assert property (ctl && writedata[0] && writedata[2]
		&& writedata[5] && idle |-> ##[1:600] (sda_oe && !scl_oe))
		else $error("no start condition after request");
	AST_SLAVE_NO_START: assert property (ctl && writedata[2] && !writedata[5]
		&& idle |=> !scl_oe [*8])
		else $error("start produced in slave mode");
	AST_IRQ_CLEAR: assert property (rd && idx == `IDX_STATUS_FLAGS && idle |=> !irq)
		else $error("interrupt stays after status read");
endmodule

// ==== dv/i2c_master_slave_control_tb_top.sv ====
/*
 * Self-checking bench for the I2C control block.
 * Assumes the bus partner model and the port checker bound below.
 */
`timescale 1ns/1ps
`include "i2c_ctrl_consts.svh"
module i2c_master_slave_control_tb_top;
	logic ref_clk = 0, rst_b = 0, read = 0, write = 0, slow = 0;
	logic fast_osc_tick = 0, low_osc_tick = 0;
	logic [11:0] address = 12'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] writedata = 32'h0, seed = 32'h442619b0, r;
	logic [2:0] tk = 3'h0;
	logic [15:0] d;
	logic [9:0] regs [10] = '{`IDX_CLOCK_SELECT, `IDX_ADDRESS_MODE, `IDX_BIT_RATE,
		`IDX_SLAVE_ADDRESS, `IDX_TRANSMIT_BUFFER, `IDX_INTERRUPT_MASK, `IDX_COMMAND_CONTROL,
		`IDX_RECEIVE_BUFFER, `IDX_STATUS_FLAGS, 10'h3c6};
	wire logic [31:0] readdata;
	wire logic waitrequest, scl_in, scl_oe, sda_in, sda_oe, irq;
	int failures = 0, tests_run = 0;
	i2c_master_slave_control uut (.ref_clk(ref_clk), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .fast_osc_tick(fast_osc_tick),
		.low_osc_tick(low_osc_tick), .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_out(), .sda_oe(sda_oe), .irq(irq));
	i2c_bus_partner far (.ref_clk(ref_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .slow(slow),
		.scl(scl_in), .sda(sda_in));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// Fast source every other cycle, slow source every eighth
	always @(posedge ref_clk) begin
		tk <= tk + 3'h1;
		fast_osc_tick <= tk[0];
		low_osc_tick <= (tk == 3'h0);
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] wmask(input logic [9:0] i);
		case (i)
			`IDX_CLOCK_SELECT: return 16'h0031;
			`IDX_ADDRESS_MODE: return 16'h0006;
			`IDX_BIT_RATE: return 16'h007f;
			`IDX_SLAVE_ADDRESS: return 16'h03ff;
			default: return 16'h00ff;
		endcase
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [9:0] i, input logic [15:0] v);
		@(posedge ref_clk);
		address <= {i, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= {16'h0, v};
		@(posedge ref_clk);
		while (waitrequest !== 1'b0) @(posedge ref_clk);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic poll_ctl(input int b);
		for (int n = 0; n < 300; n++) begin
			acc(0, `IDX_COMMAND_CONTROL, 16'h0);
			if (r[b] === 1'b0) break;
		end
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			acc(0, regs[k], 16'h0);
			chk("reset value", (k == 2) ? 32'h7f : 32'h0, r);
		end
		$display("test reset values done");
		for (int k = 0; k < 24; k++) begin
			d = xs();
			if (k % 6 == 2 && d[6:0] == 7'h0) d[0] = 1'b1;
			acc(1, regs[k % 6], d);
			acc(0, regs[k % 6], 16'h0);
			chk("readback", {16'h0, d & wmask(regs[k % 6])}, r);
		end
		acc(1, `IDX_RECEIVE_BUFFER, 16'hffff);
		acc(0, `IDX_RECEIVE_BUFFER, 16'h0);
		chk("rx read-only", 32'h0, r);
		$display("test random access done");
		acc(1, `IDX_CLOCK_SELECT, 16'h0);
		acc(1, `IDX_ADDRESS_MODE, 16'h0006);
		acc(1, `IDX_BIT_RATE, 16'h0002);
		acc(1, `IDX_INTERRUPT_MASK, 16'h0);
		acc(1, `IDX_COMMAND_CONTROL, 16'h0005);
		acc(0, `IDX_COMMAND_CONTROL, 16'h0);
		chk("slave start", 32'h1, r);
		acc(1, `IDX_ADDRESS_MODE, 16'h0);
		acc(1, `IDX_BIT_RATE, 16'h0055);
		acc(0, `IDX_ADDRESS_MODE, 16'h0);
		chk("mode lock", 32'h6, r);
		acc(0, `IDX_BIT_RATE, 16'h0);
		chk("rate lock", 32'h2, r);
		$display("test locks done");
		slow <= xs() & 1;
		// Soft reset empties the buffer left full by the random writes
		acc(1, `IDX_COMMAND_CONTROL, 16'h0003);
		acc(0, `IDX_STATUS_FLAGS, 16'h0);
		chk("tbe before load", 32'h1, r & 32'h1);
		acc(1, `IDX_TRANSMIT_BUFFER, 16'h00a4);
		acc(1, `IDX_COMMAND_CONTROL, 16'h0025);
		poll_ctl(2);
		chk("start done", 32'h21, r);
		acc(1, `IDX_COMMAND_CONTROL, 16'h0029);
		poll_ctl(3);
		chk("stop done", 32'h21, r);
		chk("lines free", 32'h3, {30'h0, scl_in, sda_in});
		chk("irq masked", 32'h0, {31'h0, irq});
		acc(1, `IDX_INTERRUPT_MASK, 16'h0018);
		@(posedge ref_clk);
		chk("irq on", 32'h1, {31'h0, irq});
		acc(0, `IDX_STATUS_FLAGS, 16'h0);
		chk("flags", 32'h19, r & 32'h19);
		$display("test master transfer done");
		acc(1, `IDX_COMMAND_CONTROL, 16'h0);
		acc(1, `IDX_COMMAND_CONTROL, 16'h0003);
		acc(0, `IDX_COMMAND_CONTROL, 16'h0);
		chk("soft reset", 32'h1, r);
		$display("test re-enable done");
		conclude();
	end
	// Whole run is several hundred cycles, far below the 20000-cycle limit
	initial begin
		#800000;
		failures++;
		conclude();
	end
endmodule
bind i2c_master_slave_control i2c_ctrl_asserts #(.ADDR_W(ADDR_W)) chk_i (.ref_clk(ref_clk),
	.rst_b(rst_b), .address(address), .read(read), .write(write), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_in),
	.scl_oe(scl_oe), .sda_in(sda_in), .sda_oe(sda_oe), .irq(irq));
